/* File: verilog/prog_link_pkg.sv */
// Shared constants for the parallel programming link: command codes,
// load selects, fuse bit positions, pin timing and controller register map.
// Assumes both ends run on one 200 MHz clock.
`default_nettype none

package prog_link_pkg;

  // ==========================================================================
  // Commands and load selects
  localparam logic [7:0] CMD_READ_FLASH = 8'h02;
  localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;

  typedef enum logic [1:0]
  {
    LOAD_COMMAND = 2'h0,
    LOAD_ADDR_HI = 2'h1,
    LOAD_ADDR_LO = 2'h2,
    LOAD_DATA_LO = 2'h3
  } load_sel_type;

  // ==========================================================================
  // Flash geometry and fuse layout
  localparam int         FLASH_WORDS_DEF = 1024;
  localparam int         ADDR_W          = 10;
  localparam logic [7:0] ADDR_HI_MASK    = 8'h03;
  localparam logic [7:0] FUSE_RESET      = 8'hFF;
  localparam int         FUSE_BIT_CAP    = 4;
  localparam int         FUSE_BIT_CK3    = 3;
  localparam int         FUSE_BIT_CK2    = 2;
  localparam int         FUSE_BIT_CK1    = 1;
  localparam int         FUSE_BUSY_DEF   = 16;

  // ==========================================================================
  // Pin timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PIN_HOLD_NS   = 20;
  localparam int ACCESS_NS     = 40;
  localparam int PIN_HOLD_CYC  = (PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_FUSE   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int         CTRL_GO_READ = 0;
  localparam int         CTRL_GO_FUSE = 1;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_DONE    = 1;

endpackage

`default_nettype wire

/* File: verilog/prog_link_if.sv */
// Pins between the external programmer and the target's programming logic.
// The shared data bus is resolved here; an undriven bus reads as all ones.
`default_nettype none

interface prog_link_if;
  logic [7:0] prog_data_out;
  logic       prog_data_oe_n;
  logic [7:0] dev_data_out;
  logic       dev_data_oe_n;
  logic [7:0] data_bus;
  logic [1:0] load_sel;
  logic       load_strobe;
  logic       out_enable_n;
  logic       byte_half_select;
  logic       write_strobe_n;
  logic       ready;

  assign data_bus = !prog_data_oe_n ? prog_data_out :
                    (!dev_data_oe_n ? dev_data_out : 8'hFF);

  modport programmer
  (
    output prog_data_out, prog_data_oe_n, load_sel, load_strobe,
    output out_enable_n, byte_half_select, write_strobe_n,
    input  data_bus, ready
  );

  modport target
  (
    output dev_data_out, dev_data_oe_n, ready,
    input  data_bus, load_sel, load_strobe, out_enable_n,
    input  byte_half_select, write_strobe_n
  );
endinterface

`default_nettype wire

/* File: verilog/flash_fuse_target.sv */
// Target end: latches command and address loads, drives flash bytes on
// read, and commits fuse bits when the busy count started by the write strobe runs out.
// Assumes link pins are asynchronous to core_clk; all are synchronised.
`default_nettype none

module flash_fuse_target #(
  parameter int         FLASH_WORDS      = prog_link_pkg::FLASH_WORDS_DEF,
  parameter int         FUSE_BUSY_CYCLES = prog_link_pkg::FUSE_BUSY_DEF,
  parameter logic [7:0] FUSE_INIT        = prog_link_pkg::FUSE_RESET
)(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Flash preload
  input  wire logic        preload_we,
  input  wire logic [9:0]  preload_addr,
  input  wire logic [15:0] preload_data,
  // Fuse state, zero means programmed
  output logic             osc_internal_cap_fuse,
  output logic             clock_source_fuse_bit3,
  output logic             clock_source_fuse_bit2,
  output logic             clock_source_fuse_bit1,
  output logic             fuse_ready,
  // Link
  prog_link_if.target      link
);

  // The busy counter is eight bits wide and the address ten, so refuse
  // anything larger at elaboration rather than wrap silently.
  if (FLASH_WORDS < 1 || FLASH_WORDS > 1024 || FUSE_BUSY_CYCLES < 1 ||
      FUSE_BUSY_CYCLES > 255)
  begin
    $error("flash_fuse_target: unsupported parameter value");
  end

  // ==========================================================================
  // Pin synchronisers
  logic [13:0] pin_s1_ff;
  logic [13:0] pin_s2_ff;
  logic        strobe_d_ff;
  logic        wr_n_d_ff;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      pin_s1_ff   <= 14'h3FFF;
      pin_s2_ff   <= 14'h3FFF;
      strobe_d_ff <= 1'b1;
      wr_n_d_ff   <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_s1_ff   <= {link.load_strobe, link.load_sel, link.out_enable_n,
                      link.byte_half_select, link.write_strobe_n, link.data_bus};
      pin_s2_ff   <= pin_s1_ff;
      strobe_d_ff <= pin_s2_ff[13];
      wr_n_d_ff   <= pin_s2_ff[8];
    end
  end

  logic                       strobe_s;
  prog_link_pkg::load_sel_type sel_s;
  logic                       oe_n_s;
  logic                       bs_s;
  logic                       wr_n_s;
  logic [7:0]                 data_s;

  always_comb
  begin
    strobe_s = pin_s2_ff[13];
    sel_s    = prog_link_pkg::load_sel_type'(pin_s2_ff[12:11]);
    oe_n_s   = pin_s2_ff[10];
    bs_s     = pin_s2_ff[9];
    wr_n_s   = pin_s2_ff[8];
    data_s   = pin_s2_ff[7:0];
  end

  // ==========================================================================
  // Flash array
  logic [15:0] flash_mem [FLASH_WORDS];

  always_ff @(posedge core_clk)
  begin
    if (preload_we && 32'(preload_addr) < FLASH_WORDS)
      flash_mem[preload_addr] <= preload_data;
  end

  // ==========================================================================
  // Command, address, fuse and read path
  logic [7:0]  cmd_ff;
  logic [7:0]  addr_hi_ff;
  logic [7:0]  addr_lo_ff;
  logic [7:0]  data_lo_ff;
  logic [7:0]  fuse_ff;
  logic [7:0]  busy_ff;
  logic [7:0]  dout_ff;
  logic        doe_n_ff;
  logic        ready_ff;
  logic [7:0]  nxt_cmd;
  logic [7:0]  nxt_addr_hi;
  logic [7:0]  nxt_addr_lo;
  logic [7:0]  nxt_data_lo;
  logic [7:0]  nxt_fuse;
  logic [7:0]  nxt_busy;
  logic [7:0]  nxt_dout;
  logic        nxt_doe_n;
  logic [15:0] word;
  logic [9:0]  waddr;

  always_comb
  begin
    nxt_cmd     = cmd_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_addr_lo = addr_lo_ff;
    nxt_data_lo = data_lo_ff;
    nxt_fuse    = fuse_ff;
    nxt_busy    = busy_ff;
    waddr       = {addr_hi_ff[1:0], addr_lo_ff};
    word        = (32'(waddr) < FLASH_WORDS) ? flash_mem[waddr] : 16'hFFFF;
    if (busy_ff != 8'h00)
    begin
      nxt_busy = busy_ff - 8'h01;
      if (busy_ff == 8'h01)
        nxt_fuse = data_lo_ff;
    end
    else
    begin
      // Loads are ignored while a fuse commit is in progress.
      if (strobe_s && !strobe_d_ff)
      begin
        case (sel_s)
          prog_link_pkg::LOAD_COMMAND: nxt_cmd = data_s;
          prog_link_pkg::LOAD_ADDR_HI: nxt_addr_hi = data_s;
          prog_link_pkg::LOAD_ADDR_LO: nxt_addr_lo = data_s;
          prog_link_pkg::LOAD_DATA_LO: nxt_data_lo = data_s;
          default:                     nxt_cmd = cmd_ff;
        endcase
      end
      if (!wr_n_s && wr_n_d_ff && cmd_ff == prog_link_pkg::CMD_WRITE_FUSE)
        nxt_busy = 8'(FUSE_BUSY_CYCLES);
    end
    if (!oe_n_s && cmd_ff == prog_link_pkg::CMD_READ_FLASH && busy_ff == 8'h00)
    begin
      nxt_doe_n = 1'b0;
      nxt_dout  = bs_s ? word[15:8] : word[7:0];
    end
    else
    begin
      nxt_doe_n = 1'b1;
      nxt_dout  = 8'hFF;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cmd_ff     <= 8'h00;
      addr_hi_ff <= 8'h00;
      addr_lo_ff <= 8'h00;
      data_lo_ff <= 8'hFF;
      fuse_ff    <= FUSE_INIT;
      busy_ff    <= 8'h00;
      dout_ff    <= 8'hFF;
      doe_n_ff   <= 1'b1;
      ready_ff   <= 1'b1;
    end
    else if (clk_en)
    begin
      cmd_ff     <= nxt_cmd;
      addr_hi_ff <= nxt_addr_hi;
      addr_lo_ff <= nxt_addr_lo;
      data_lo_ff <= nxt_data_lo;
      fuse_ff    <= nxt_fuse;
      busy_ff    <= nxt_busy;
      dout_ff    <= nxt_dout;
      doe_n_ff   <= nxt_doe_n;
      ready_ff   <= (nxt_busy == 8'h00);
    end
  end

  assign link.dev_data_out       = dout_ff;
  assign link.dev_data_oe_n      = doe_n_ff;
  assign link.ready              = ready_ff;
  assign fuse_ready              = ready_ff;
  assign osc_internal_cap_fuse   = fuse_ff[prog_link_pkg::FUSE_BIT_CAP];
  assign clock_source_fuse_bit3  = fuse_ff[prog_link_pkg::FUSE_BIT_CK3];
  assign clock_source_fuse_bit2  = fuse_ff[prog_link_pkg::FUSE_BIT_CK2];
  assign clock_source_fuse_bit1  = fuse_ff[prog_link_pkg::FUSE_BIT_CK1];

endmodule

`default_nettype wire

/* File: verilog/flash_fuse_programmer.sv */
// Programmer end: software orders a flash word read or a fuse write through
// a small register port; this module sequences the link pins.
// Assumes the target sits on the same link and answers within pin timing.
`default_nettype none

module flash_fuse_programmer (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // Link
  prog_link_if.programmer  link
);

  typedef enum logic [3:0]
  {
    ST_IDLE      = 4'h0,
    ST_LOAD_SET  = 4'h1,
    ST_LOAD_HIGH = 4'h2,
    ST_LOAD_LOW  = 4'h3,
    ST_RD_LO     = 4'h4,
    ST_RD_HI     = 4'h5,
    ST_RD_END    = 4'h6,
    ST_WR_LOW    = 4'h7,
    ST_WR_HIGH   = 4'h8,
    ST_WAIT_RDY  = 4'h9
  } state_type;

  // Lowest pending load goes first: command, address high, low, data.
  function automatic logic [1:0] first_load(input logic [3:0] need);
    first_load = 2'h3;
    for (int i = 3; i >= 0; i--)
    begin
      if (need[i])
        first_load = 2'(i);
    end
  endfunction

  // ==========================================================================
  // Link synchronisers
  logic [8:0] in_s1_ff;
  logic [8:0] in_s2_ff;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      in_s1_ff <= 9'h000;
      in_s2_ff <= 9'h000;
    end
    else if (clk_en)
    begin
      in_s1_ff <= {link.ready, link.data_bus};
      in_s2_ff <= in_s1_ff;
    end
  end

  // ==========================================================================
  // Sequencer and registers
  state_type  state_ff;
  state_type  nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [3:0] need_ff;
  logic [3:0] nxt_need;
  logic       op_fuse_ff;
  logic       nxt_op_fuse;
  logic [9:0] addr_ff;
  logic [9:0] nxt_addr;
  logic [7:0] fuse_ff;
  logic [7:0] nxt_fuse;
  logic [15:0] rword_ff;
  logic [15:0] nxt_rword;
  logic       done_ff;
  logic       nxt_done;
  logic [7:0] cmd_last_ff;
  logic [7:0] nxt_cmd_last;
  logic       cmd_valid_ff;
  logic       nxt_cmd_valid;
  logic [7:0] hi_last_ff;
  logic [7:0] nxt_hi_last;
  logic       hi_valid_ff;
  logic       nxt_hi_valid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] dout_ff;
  logic [7:0] nxt_dout;
  logic       doe_n_ff;
  logic       nxt_doe_n;
  logic [1:0] sel_ff;
  logic [1:0] nxt_sel;
  logic       strobe_ff;
  logic       nxt_strobe;
  logic       oe_n_ff;
  logic       nxt_oe_n;
  logic       bs_ff;
  logic       nxt_bs;
  logic       wr_n_ff;
  logic       nxt_wr_n;
  logic [7:0] op_cmd;
  logic [7:0] hi_byte;
  logic [7:0] load_byte;
  logic       ready_s;
  logic [7:0] data_s;

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_cnt       = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    nxt_need      = need_ff;
    nxt_op_fuse   = op_fuse_ff;
    nxt_addr      = addr_ff;
    nxt_fuse      = fuse_ff;
    nxt_rword     = rword_ff;
    nxt_done      = done_ff;
    nxt_cmd_last  = cmd_last_ff;
    nxt_cmd_valid = cmd_valid_ff;
    nxt_hi_last   = hi_last_ff;
    nxt_hi_valid  = hi_valid_ff;
    nxt_rdata     = 32'h0000_0000;
    nxt_dout      = dout_ff;
    nxt_doe_n     = doe_n_ff;
    nxt_sel       = sel_ff;
    nxt_strobe    = strobe_ff;
    nxt_oe_n      = oe_n_ff;
    nxt_bs        = bs_ff;
    nxt_wr_n      = wr_n_ff;
    ready_s       = in_s2_ff[8];
    data_s        = in_s2_ff[7:0];
    op_cmd        = op_fuse_ff ? prog_link_pkg::CMD_WRITE_FUSE
                               : prog_link_pkg::CMD_READ_FLASH;
    hi_byte       = {6'h00, addr_ff[9:8]} & prog_link_pkg::ADDR_HI_MASK;
    case (first_load(need_ff))
      2'h0:    load_byte = op_cmd;
      2'h1:    load_byte = hi_byte;
      2'h2:    load_byte = addr_ff[7:0];
      default: load_byte = fuse_ff;
    endcase

    if (reg_read)
    begin
      case (reg_addr)
        prog_link_pkg::REG_ADDR:   nxt_rdata = {22'h0, addr_ff};
        prog_link_pkg::REG_FUSE:   nxt_rdata = {24'h0, fuse_ff};
        prog_link_pkg::REG_STATUS: nxt_rdata = {30'h0, done_ff, state_ff != ST_IDLE};
        prog_link_pkg::REG_RDATA:  nxt_rdata = {16'h0, rword_ff};
        default:                   nxt_rdata = 32'h0000_0000;
      endcase
    end

    case (state_ff)
      ST_IDLE:
      begin
        if (reg_write && reg_addr == prog_link_pkg::REG_ADDR)
          nxt_addr = reg_wdata[9:0];
        if (reg_write && reg_addr == prog_link_pkg::REG_FUSE)
          nxt_fuse = reg_wdata[7:0];
        if (reg_write && reg_addr == prog_link_pkg::REG_CTRL &&
            (reg_wdata[prog_link_pkg::CTRL_GO_READ] ||
             reg_wdata[prog_link_pkg::CTRL_GO_FUSE]))
        begin
          nxt_op_fuse = reg_wdata[prog_link_pkg::CTRL_GO_FUSE];
          nxt_done    = 1'b0;
          op_cmd      = nxt_op_fuse ? prog_link_pkg::CMD_WRITE_FUSE
                                    : prog_link_pkg::CMD_READ_FLASH;
          nxt_need[0] = !cmd_valid_ff || cmd_last_ff != op_cmd;
          nxt_need[1] = !nxt_op_fuse &&
                        (!hi_valid_ff || hi_last_ff != hi_byte);
          nxt_need[2] = !nxt_op_fuse;
          nxt_need[3] = nxt_op_fuse;
          nxt_state   = ST_LOAD_SET;
        end
      end
      ST_LOAD_SET:
      begin
        // With every pending load latched, start the read or the write strobe.
        if (need_ff == 4'h0)
        begin
          nxt_state = op_fuse_ff ? ST_WR_LOW : ST_RD_LO;
          nxt_wr_n  = !op_fuse_ff;
          nxt_oe_n  = op_fuse_ff;
          nxt_bs    = 1'b0;
          nxt_cnt   = op_fuse_ff ? 8'(prog_link_pkg::PIN_HOLD_CYC)
                                 : 8'(prog_link_pkg::ACCESS_CYC);
        end
        else
        begin
          nxt_sel   = first_load(need_ff);
          nxt_dout  = load_byte;
          nxt_doe_n = 1'b0;
          nxt_cnt   = 8'(prog_link_pkg::PIN_HOLD_CYC);
          nxt_state = ST_LOAD_HIGH;
        end
      end
      ST_LOAD_HIGH:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_strobe = 1'b1;
          nxt_cnt    = 8'(prog_link_pkg::PIN_HOLD_CYC);
          nxt_state  = ST_LOAD_LOW;
        end
      end
      ST_LOAD_LOW:
      begin
        if (cnt_ff == 8'h00 && strobe_ff)
        begin
          nxt_strobe = 1'b0;
          nxt_cnt    = 8'(prog_link_pkg::PIN_HOLD_CYC);
        end
        else if (cnt_ff == 8'h00)
        begin
          nxt_doe_n = 1'b1;
          nxt_need[sel_ff] = 1'b0;
          if (sel_ff == 2'h0)
          begin
            nxt_cmd_last  = dout_ff;
            nxt_cmd_valid = 1'b1;
          end
          if (sel_ff == 2'h1)
          begin
            nxt_hi_last  = dout_ff;
            nxt_hi_valid = 1'b1;
          end
          nxt_state = ST_LOAD_SET;
        end
      end
      ST_RD_LO:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_rword[7:0] = data_s;
          nxt_bs         = 1'b1;
          nxt_cnt        = 8'(prog_link_pkg::ACCESS_CYC);
          nxt_state      = ST_RD_HI;
        end
      end
      ST_RD_HI:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_rword[15:8] = data_s;
          nxt_oe_n        = 1'b1;
          nxt_bs          = 1'b0;
          nxt_cnt         = 8'(prog_link_pkg::ACCESS_CYC);
          nxt_state       = ST_RD_END;
        end
      end
      ST_RD_END:
      begin
        // Wait out the target's release before any new load drives the bus.
        if (cnt_ff == 8'h00)
        begin
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_WR_LOW:
      begin
        if (cnt_ff == 8'h00)
        begin
          nxt_wr_n  = 1'b1;
          nxt_cnt   = 8'(prog_link_pkg::ACCESS_CYC);
          nxt_state = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH:
      begin
        if (cnt_ff == 8'h00)
          nxt_state = ST_WAIT_RDY;
      end
      ST_WAIT_RDY:
      begin
        if (ready_s)
        begin
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 8'h00;
      need_ff      <= 4'h0;
      op_fuse_ff   <= 1'b0;
      addr_ff      <= 10'h000;
      fuse_ff      <= prog_link_pkg::FUSE_RESET;
      rword_ff     <= 16'h0000;
      done_ff      <= 1'b0;
      cmd_last_ff  <= 8'h00;
      cmd_valid_ff <= 1'b0;
      hi_last_ff   <= 8'h00;
      hi_valid_ff  <= 1'b0;
      rdata_ff     <= 32'h0000_0000;
      dout_ff      <= 8'hFF;
      doe_n_ff     <= 1'b1;
      sel_ff       <= 2'h0;
      strobe_ff    <= 1'b0;
      oe_n_ff      <= 1'b1;
      bs_ff        <= 1'b0;
      wr_n_ff      <= 1'b1;
    end
    else if (clk_en)
    begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      need_ff      <= nxt_need;
      op_fuse_ff   <= nxt_op_fuse;
      addr_ff      <= nxt_addr;
      fuse_ff      <= nxt_fuse;
      rword_ff     <= nxt_rword;
      done_ff      <= nxt_done;
      cmd_last_ff  <= nxt_cmd_last;
      cmd_valid_ff <= nxt_cmd_valid;
      hi_last_ff   <= nxt_hi_last;
      hi_valid_ff  <= nxt_hi_valid;
      rdata_ff     <= nxt_rdata;
      dout_ff      <= nxt_dout;
      doe_n_ff     <= nxt_doe_n;
      sel_ff       <= nxt_sel;
      strobe_ff    <= nxt_strobe;
      oe_n_ff      <= nxt_oe_n;
      bs_ff        <= nxt_bs;
      wr_n_ff      <= nxt_wr_n;
    end
  end

  assign reg_rdata             = rdata_ff;
  assign link.prog_data_out    = dout_ff;
  assign link.prog_data_oe_n   = doe_n_ff;
  assign link.load_sel         = sel_ff;
  assign link.load_strobe      = strobe_ff;
  assign link.out_enable_n     = oe_n_ff;
  assign link.byte_half_select = bs_ff;
  assign link.write_strobe_n   = wr_n_ff;

endmodule

`default_nettype wire

/* File: tb/prog_link_props.sv */
// Checker on the link pins between the programmer and the target.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

module prog_link_props (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Link pins
  input wire logic [7:0] data_bus,
  input wire logic       prog_data_oe_n,
  input wire logic       dev_data_oe_n,
  input wire logic [1:0] load_sel,
  input wire logic       load_strobe,
  input wire logic       out_enable_n,
  input wire logic       byte_half_select,
  input wire logic       write_strobe_n,
  input wire logic       ready
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Loads
  AST_CMD_CODE: assert property (
    $rose(load_strobe) && load_sel == 2'h0 |-> data_bus == prog_link_pkg::CMD_READ_FLASH
      || data_bus == prog_link_pkg::CMD_WRITE_FUSE) else $error("bad command code");
  AST_HI_RANGE: assert property (
    load_strobe && load_sel == 2'h1 |-> data_bus <= 8'h03) else $error("address high too big");
  AST_LOAD_HOLD: assert property (
    $rose(load_strobe) |-> (load_strobe && !prog_data_oe_n && $stable(data_bus))[*4])
    else $error("load strobe too short");

  // ==========================================================================
  // Reads
  AST_DRIVE_ON_OE: assert property (
    $fell(dev_data_oe_n) |-> !out_enable_n) else $error("target drove without enable");
  AST_OE_ANSWER: assert property (
    $fell(out_enable_n) |-> ##[1:6] !dev_data_oe_n) else $error("target did not answer");
  AST_BS_IN_READ: assert property (
    $rose(byte_half_select) |-> !out_enable_n) else $error("select rose outside read");
  AST_RELEASE: assert property (
    $rose(out_enable_n) |-> ##[1:6] dev_data_oe_n) else $error("bus not released");
  AST_NO_CLASH: assert property (
    !prog_data_oe_n |-> dev_data_oe_n) else $error("bus driven by both ends");

  // ==========================================================================
  // Fuse commit
  AST_WR_BUSY: assert property (
    $fell(write_strobe_n) |-> ##[2:8] !ready) else $error("no busy after write");
  AST_NO_LOAD_BUSY: assert property (
    !ready |-> !$rose(load_strobe)) else $error("load while busy");
endmodule

`default_nettype wire

/* File: tb/parallel_flash_read_fuse_write_tb.sv */
// Testbench: programmer and target joined, driven through the register port.
// Assumes the register map and fuse layout of prog_link_pkg.
`default_nettype none

module parallel_flash_read_fuse_write_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        reset_n;
  logic        clk_en;
  int          loads = 0;
  int          last_cmd = -1;
  int          last_hi = -1;
  logic        preload_we;
  logic [9:0]  preload_addr;
  logic [15:0] preload_data;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic [3:0]  fuse_out;
  logic        fuse_ready;
  logic [31:0] rd;
  int          error_cnt;
  int          checks;
  int          mem [1024];
  logic [9:0]  addrs [6] = '{10'h000, 10'h3FF, 10'h0FF, 10'h100, 10'h101, 10'h200};
  logic [7:0]  fuses [6] = '{8'hEF, 8'hF7, 8'hFB, 8'hFD, 8'h00, 8'hFF};

  prog_link_if prog_link_if_i ();

  flash_fuse_target flash_fuse_target_i (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .preload_we(preload_we),
    .preload_addr(preload_addr), .preload_data(preload_data),
    .osc_internal_cap_fuse(fuse_out[3]), .clock_source_fuse_bit3(fuse_out[2]),
    .clock_source_fuse_bit2(fuse_out[1]), .clock_source_fuse_bit1(fuse_out[0]),
    .fuse_ready(fuse_ready), .link(prog_link_if_i.target));

  flash_fuse_programmer flash_fuse_programmer_i (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link(prog_link_if_i.programmer));

  prog_link_props prog_link_props_i (
    .core_clk(core_clk), .reset_n(reset_n), .data_bus(prog_link_if_i.data_bus),
    .prog_data_oe_n(prog_link_if_i.prog_data_oe_n), .dev_data_oe_n(prog_link_if_i.dev_data_oe_n),
    .load_sel(prog_link_if_i.load_sel), .load_strobe(prog_link_if_i.load_strobe),
    .out_enable_n(prog_link_if_i.out_enable_n),
    .byte_half_select(prog_link_if_i.byte_half_select),
    .write_strobe_n(prog_link_if_i.write_strobe_n), .ready(prog_link_if_i.ready));

  always #2.5 core_clk = ~core_clk;

  // Every latched byte on the link costs one strobe; skipped loads show up here.
  always @(posedge prog_link_if_i.load_strobe)
    loads++;

  function automatic logic [7:0] link_pins();
    return {prog_link_if_i.load_sel, prog_link_if_i.load_strobe, prog_link_if_i.out_enable_n,
            prog_link_if_i.byte_half_select, prog_link_if_i.write_strobe_n,
            prog_link_if_i.prog_data_oe_n, fuse_ready};
  endfunction

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic reg_rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic wait_done();
    for (int i = 0; i < 3000; i++)
    begin
      reg_rd(prog_link_pkg::REG_STATUS);
      if (rd[1:0] === 2'b10)
        return;
    end
    check("done wait", 32'h1, 32'h0);
    wrap_up();
  endtask

  task automatic do_read(input logic [9:0] a, input bit freeze = 1'b0);
    logic [7:0] pins;
    int         n0;
    int         exp_loads;
    n0        = loads;
    exp_loads = 1 + ((last_cmd != int'(prog_link_pkg::CMD_READ_FLASH)) ? 1 : 0) +
                ((int'(a[9:8]) != last_hi) ? 1 : 0);
    reg_wr(prog_link_pkg::REG_ADDR, {22'h0, a});
    reg_wr(prog_link_pkg::REG_CTRL, 32'h1);
    if (freeze)
    begin
      // Freeze both ends mid-sequence; no pin may move until the enable returns.
      repeat (20) @(posedge core_clk);
      clk_en <= 1'b0;
      @(posedge core_clk);
      #1 pins = link_pins();
      repeat (40) @(posedge core_clk);
      check("frozen pins", {24'h0, link_pins()}, {24'h0, pins});
      clk_en <= 1'b1;
    end
    wait_done();
    reg_rd(prog_link_pkg::REG_RDATA);
    check("low byte", {24'h0, rd[7:0]}, 32'(mem[a] & 'hFF));
    check("high byte", {24'h0, rd[15:8]}, 32'(mem[a] >> 8));
    check("read loads", 32'(loads - n0), 32'(exp_loads));
    last_cmd = int'(prog_link_pkg::CMD_READ_FLASH);
    last_hi  = int'(a[9:8]);
  endtask

  task automatic do_fuse(input logic [7:0] v);
    int n0;
    int exp_loads;
    n0        = loads;
    exp_loads = 1 + ((last_cmd != int'(prog_link_pkg::CMD_WRITE_FUSE)) ? 1 : 0);
    reg_wr(prog_link_pkg::REG_FUSE, {24'h0, v});
    reg_wr(prog_link_pkg::REG_CTRL, 32'h2);
    reg_rd(prog_link_pkg::REG_STATUS);
    check("busy", {31'h0, rd[0]}, 32'h1);
    wait_done();
    check("fuse bits", {28'h0, fuse_out}, {28'h0, v[4:1]});
    check("fuse ready", {31'h0, fuse_ready}, 32'h1);
    check("fuse loads", 32'(loads - n0), 32'(exp_loads));
    last_cmd = int'(prog_link_pkg::CMD_WRITE_FUSE);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    core_clk   = 1'b0;
    reset_n    = 1'b0;
    clk_en     = 1'b1;
    preload_we = 1'b0;
    reg_write  = 1'b0;
    reg_read   = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    error_cnt  = 0;
    checks     = 0;
    void'($urandom(32'hD7DD));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 1024; i++)
    begin
      @(posedge core_clk);
      mem[i] = $urandom() & 'hFFFF;
      preload_we   <= 1'b1;
      preload_addr <= 10'(i);
      preload_data <= mem[i][15:0];
    end
    @(posedge core_clk);
    preload_we <= 1'b0;
    check("fuse reset", {28'h0, fuse_out}, 32'hF);
    reg_rd(prog_link_pkg::REG_STATUS);
    check("status reset", rd, 32'h0);
    reg_rd(8'hFC);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
    foreach (addrs[i])
      do_read(addrs[i]);
    repeat (6)
      do_read(10'($urandom()));
    $display("test reads done");
    foreach (fuses[i])
      do_fuse(fuses[i]);
    do_fuse(8'($urandom()));
    do_read(10'($urandom()), 1'b1);
    $display("test fuses done");
    wrap_up();
  end
endmodule

`default_nettype wire
